// ===== core/sarf_map.vh
`ifndef SARF_MAP_VH
`define SARF_MAP_VH
`define SARF_RES_W        14
`define SARF_CNT_W        5
`define SARF_LEAD_ZEROS   5'd2
`define SARF_CONV_EDGES   5'd15
`define SARF_LAST_EDGE    5'd16
`define SARF_TRACK_PERIODS 5'd3
`define SARF_FRAME_EDGES  5'd19
`define SARF_POS_FULL     14'h1fff
`define SARF_NEG_FULL     14'h2000
`endif

// ===== core/sarf_readout.v
// How it works
// - A frame starts when select falls and ends when select rises.
// - Data output is driven only while select is low, floated otherwise.
// - Input sampled at select assertion; digitizing runs the next fifteen clock periods.
// - On the sixteenth falling edge the block enters the tracking phase.
// - Tracking lasts from the sixteenth falling edge until select rises; the next three clock falls are only counted.
// - Select falling with clock high: digitizing starts at once; the next clock fall counts as the first.
// - Select falling with clock low counts as the first falling edge.
// - Select and clock falling together start digitizing at once.
// - While select is high the block stays in tracking, ignoring clock.
// - Output changes on clock falls: two zeros, then fourteen bits MSB first.
// - Result is two's complement, clipped to 1fff and 2000 at full scale.
// - Select rising before the sixteenth fall aborts and floats the output.
`timescale 1ns/10ps
`default_nettype none
`include "sarf_map.vh"

// Three-flop pin synchroniser; a change counts once the second and third flops agree.
module sarf_sync3 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk_sys_i,
  input  wire rst_i,
  input  wire pin_i,
  output reg  level_o,
  output wire level_new_o
);
  reg [2:0] stg_q;
  wire      agree;

  // Waiting for agreement filters a single-cycle glitch caught by the first flop.
  assign agree       = (stg_q[1] == stg_q[2]);
  assign level_new_o = agree ? stg_q[2] : level_o;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stg_q   <= {3{RST_VAL}};
      level_o <= RST_VAL;
    end else begin
      stg_q   <= {stg_q[1:0], pin_i};
      level_o <= level_new_o;
    end
  end
endmodule // sarf_sync3

module sarf_readout (
  input  wire        clk_sys_i,
  input  wire        rst_i,
  input  wire        sel_n_i,
  input  wire        sclk_i,
  input  wire [15:0] sample_i,
  input  wire        sample_valid_i,
  output wire        sample_ready_o,
  output wire        sdo_o,
  output wire        sdo_oe_o,
  output wire        digitizing_o,
  output wire        tracking_o,
  output reg         aborted_o
);
  localparam ST_TRACK = 2'd0;
  localparam ST_WAIT  = 2'd1;
  localparam ST_CONV  = 2'd2;
  localparam ST_ACQ   = 2'd3;

  // Registered pin levels and the value each will take at the coming edge.
  wire sel_q;
  wire sel_new;
  wire sck_q;
  wire sck_new;

  sarf_sync3 #(
    .RST_VAL (1'b1)
  ) i_sel_sync (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .pin_i       (sel_n_i),
    .level_o     (sel_q),
    .level_new_o (sel_new)
  );

  // The serial clock is only sampled, so its edges show up three to four cycles late.
  sarf_sync3 #(
    .RST_VAL (1'b0)
  ) i_sck_sync (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .pin_i       (sclk_i),
    .level_o     (sck_q),
    .level_new_o (sck_new)
  );

  // Edges come from the next-value wires, so the phase register moves at the same edge
  // as the synchronised level and the output enable.
  wire sel_fall = sel_q & ~sel_new;
  wire sel_rise = ~sel_q & sel_new;
  wire sck_fall = sck_q & ~sck_new;

  // Two-entry buffer holding converter results; the frame takes one word when it starts.
  reg [15:0] buf_q [0:1];
  reg        wr_q;
  reg        rd_q;
  reg [1:0]  cnt_q;
  // Read side: a word is offered while one is held and taken as a frame opens.
  wire       buf_put;
  wire       buf_valid;
  wire       buf_take;
  assign buf_valid      = (cnt_q != 2'd0);
  assign buf_take       = sel_fall & buf_valid;
  assign buf_put        = sample_valid_i & sample_ready_o;
  assign sample_ready_o = (cnt_q != 2'd2);

  // The storage has no reset; the count alone says which entries hold data.
  always @(posedge clk_sys_i) begin
    if (buf_put)
      buf_q[wr_q] <= sample_i;
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (buf_put)
        wr_q <= ~wr_q;
      if (buf_take)
        rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, buf_put} - {1'b0, buf_take};
    end
  end

  // Saturate the signed input to the 14-bit code range.
  // Codes beyond fourteen bits clip rather than wrap, so an overload never flips the sign.
  wire [15:0] raw = buf_q[rd_q];
  reg  [13:0] code;
  always @* begin
    if (!raw[15] && raw[14:13] != 2'b00)
      code = `SARF_POS_FULL;
    else if (raw[15] && raw[14:13] != 2'b11)
      code = `SARF_NEG_FULL;
    else
      code = raw[13:0];
  end

  // Phase register: idle tracking, waiting for the first clock fall, digitizing, tracking.
  reg [1:0]  st_q;
  reg [4:0]  fall_q;
  wire [4:0] fall_next = fall_q + 5'd1;
  reg [15:0] shf_q;
  reg        dout_q;
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      st_q      <= ST_TRACK;
      fall_q    <= 5'd0;
      shf_q     <= 16'h0000;
      dout_q    <= 1'b0;
      aborted_o <= 1'b0;
    end else begin
      aborted_o <= 1'b0;
      if (sel_rise) begin
        st_q <= ST_TRACK;
        if (st_q == ST_WAIT || st_q == ST_CONV)
          aborted_o <= 1'b1;
      end else if (sel_q && !sel_fall) begin
        // A falling select is handled in the case below, so it must not be swallowed here.
        st_q <= ST_TRACK;
      end else begin
        case (st_q)
          ST_TRACK: begin
            if (sel_fall) begin
              // Sample is frozen here so later buffer writes cannot disturb it.
              shf_q <= {2'b00, (cnt_q != 2'd0) ? code : 14'h0000};
              dout_q <= 1'b0;
              if (sck_new) begin
                st_q   <= ST_WAIT;
                fall_q <= 5'd0;
              end else begin
                st_q   <= ST_CONV;
                fall_q <= 5'd1;
              end
            end
          end
          ST_WAIT: begin
            // Select fell with the clock high; the next clock fall is the first of the frame.
            if (sck_fall) begin
              st_q   <= ST_CONV;
              fall_q <= 5'd1;
            end
          end
          ST_CONV: begin
            if (sck_fall) begin
              fall_q <= fall_next;
              // Two leading zeros, then the result MSB first.
              dout_q <= shf_q[14];
              shf_q  <= {shf_q[14:0], 1'b0};
              if (fall_next == `SARF_LAST_EDGE)
                st_q <= ST_ACQ;
            end
          end
          ST_ACQ: begin
            // Tracking needs no clock edges; it counts up to three more clock falls while it waits for select to rise.
            if (sck_fall && fall_q != `SARF_FRAME_EDGES)
              fall_q <= fall_q + 5'd1;
          end
          default: st_q <= ST_TRACK;
        endcase
      end
    end
  end

  assign sdo_o        = dout_q;
  // The select alone enables the output, so an aborted frame floats as soon as select rises.
  assign sdo_oe_o     = ~sel_q;
  assign digitizing_o = (st_q == ST_CONV) || (st_q == ST_WAIT);
  assign tracking_o   = ~digitizing_o;
endmodule // sarf_readout
`default_nettype wire

// ===== tb/sarf_readout_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module sarf_chk (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic sel_n_i,
  input wire logic sclk_i,
  input wire logic sdo_o,
  input wire logic sdo_oe_o,
  input wire logic digitizing_o,
  input wire logic tracking_o,
  input wire logic aborted_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Five samples cover the three-flop pin synchroniser plus one register.
  sequence s_low; !sel_n_i[*5]; endsequence
  sequence s_high; sel_n_i[*5]; endsequence
  a_oe_on: assert property (s_low |-> sdo_oe_o)
    else $error("output not driven");
  a_oe_off: assert property (s_high |-> !sdo_oe_o)
    else $error("output not floated");
  a_idle_track: assert property (s_high |-> tracking_o)
    else $error("not tracking");
  a_conv_needs_sel: assert property (digitizing_o |-> sdo_oe_o)
    else $error("digitizing without select");
  a_start_conv: assert property ($rose(sdo_oe_o) |-> ##[0:1] digitizing_o)
    else $error("no conversion");
  a_abort_pulse: assert property (aborted_o |=> !aborted_o)
    else $error("long abort");
  a_abort_float: assert property (aborted_o |-> ##[0:2] !sdo_oe_o)
    else $error("abort kept drive");
  a_sdo_steady: assert property ((sclk_i && sdo_oe_o)[*3] |-> $stable(sdo_o))
    else $error("data moved");
endmodule // sarf_chk
bind sarf_readout sarf_chk i_chk (.clk_sys_i, .rst_i, .sel_n_i, .sclk_i, .sdo_o, .sdo_oe_o,
  .digitizing_o, .tracking_o, .aborted_o);
`default_nettype wire

// ===== tb/sarf_host.sv
`timescale 1ns/10ps
`default_nettype none
module sarf_host (
  output logic sel_n_o,
  output logic sclk_o,
  input  wire logic sdo_i
);
  logic [17:0] cap_q;
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  // Capture late in the high phase, since the synchroniser delays the data.
  task automatic frame(input int n, input bit hi);
    sclk_o = hi;
    #64 sel_n_o = 1'b0;
    if (hi) #32;
    for (int i = 1; i <= n; i++) begin
      if (i > 1 || hi) sclk_o = 1'b0;
      #32 sclk_o = 1'b1;
      #30 cap_q = {cap_q[16:0], sdo_i};
      #2;
    end
    #64 sel_n_o = 1'b1;
  endtask
endmodule // sarf_host
`default_nettype wire

// ===== tb/sarf_readout_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sarf_readout_tb;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] smp = 16'h0000;
  logic vld = 1'b0;
  wire sel_n, sclk, rdy, sdo, oe, dig, trk, abt;
  wire sdo_w = oe ? sdo : 1'bz;
  int failures = 0;
  int check_count = 0;
  int aborts = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (abt === 1'b1) aborts++;
  sarf_host i_host (.sel_n_o(sel_n), .sclk_o(sclk), .sdo_i(sdo_w));
  sarf_readout i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sel_n_i(sel_n), .sclk_i(sclk),
    .sample_i(smp), .sample_valid_i(vld), .sample_ready_o(rdy), .sdo_o(sdo),
    .sdo_oe_o(oe), .digitizing_o(dig), .tracking_o(trk), .aborted_o(abt));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic push(input logic [15:0] v);
    @(posedge clk_sys_i) #1 smp = v;
    vld = 1'b1;
    while (rdy !== 1'b1) begin
      @(posedge clk_sys_i) #1;
    end
    @(posedge clk_sys_i) #1 vld = 1'b0;
  endtask
  task automatic t_code(input logic [15:0] v, input logic [15:0] e, input bit hi);
    push(v);
    i_host.frame(18, hi);
    chk("word", e, i_host.cap_q[17:2]);
    chk("track", 16'h0001, {15'h0, trk});
  endtask
  task automatic t_abort();
    push(16'h0123);
    i_host.frame(5, 1'b0);
    repeat (8) @(posedge clk_sys_i);
    chk("aborts", 16'h0001, aborts[15:0]);
    chk("float", {15'h0000, 1'bz}, {15'h0, sdo_w});
    chk("digitizing", 16'h0000, {15'h0, dig});
  endtask
  task automatic t_buf();
    push(16'h0011);
    push(16'hffee);
    chk("ready", 16'h0000, {15'h0, rdy});
    i_host.frame(18, 1'b0);
    chk("first", 16'h0011, i_host.cap_q[17:2]);
    push(16'h0022);
    i_host.frame(18, 1'b0);
    chk("second", 16'h3fee, i_host.cap_q[17:2]);
    i_host.frame(18, 1'b0);
    chk("third", 16'h0022, i_host.cap_q[17:2]);
  endtask
  task automatic test_done();
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    #1 rst_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    t_code(16'h2000, 16'h1fff, 1'b1);
    t_code(16'hdfff, 16'h2000, 1'b0);
    t_abort();
    t_code(16'h1555, 16'h1555, 1'b0);
    t_buf();
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule // sarf_readout_tb
`default_nettype wire
